// File: design/aom_pkg.sv
// Package: constants, types and helpers for the converter output control block
package aom_pkg;
    localparam int RES_W = 11;
    localparam int LVL_W = 13;
    localparam logic signed [LVL_W-1:0] CODE_MIN = 13'sh0000;
    localparam logic signed [LVL_W-1:0] CODE_MAX = 13'sh07FF;
    // Register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h08;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0C;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_LAST_RESULT = 8'h14;
    localparam logic [7:0] OFS_SAMPLE_COUNT = 8'h18;
    // Interrupt bit positions
    localparam int IRQ_W = 3;
    localparam int IRQ_SAMPLE = 0;
    localparam int IRQ_OVER = 1;
    localparam int IRQ_POWER = 2;
    // Strap codes
    localparam logic [1:0] CF_DIFF_TWOS = 2'h3;
    localparam logic [1:0] CF_DIFF_OFFS = 2'h2;
    localparam logic [1:0] CF_SE_TWOS = 2'h1;
    localparam logic [1:0] CF_SE_OFFS = 2'h0;
    localparam logic [1:0] PS_DOWN = 2'h2;
    localparam logic [1:0] PS_SLEEP = 2'h1;
    // Reset values and bus response codes
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {AOM_NORMAL, AOM_SLEEP, AOM_DOWN} aom_power_t;

    typedef struct packed {
        logic diff_clk;
        logic twos;
    } aom_cfg_t;

    typedef struct packed {
        logic over;
        logic [RES_W-1:0] word;
    } aom_result_t;

    function automatic aom_cfg_t decode_cfg(input logic [1:0] s);
        aom_cfg_t c;
        c.diff_clk = s[1];
        c.twos = (s == CF_DIFF_TWOS) || (s == CF_SE_TWOS);
        return c;
    endfunction

    function automatic aom_power_t decode_power(input logic [1:0] s);
        aom_power_t p;
        p = (s == PS_SLEEP) ? AOM_SLEEP : (s == 2'h0) ? AOM_NORMAL : AOM_DOWN;
        return p;
    endfunction

    function automatic aom_result_t convert(input logic signed [LVL_W-1:0] lvl, input logic twos);
        aom_result_t r;
        logic [RES_W-1:0] ob;
        r.over = (lvl < CODE_MIN) || (lvl > CODE_MAX);
        ob = (lvl < CODE_MIN) ? CODE_MIN[RES_W-1:0] : (lvl > CODE_MAX) ? CODE_MAX[RES_W-1:0] : lvl[RES_W-1:0];
        r.word = twos ? {~ob[RES_W-1], ob[RES_W-2:0]} : ob;
        return r;
    endfunction
endpackage

// File: design/aom_ctrl.sv
// Converter output control: strap decode, sample timing, result outputs, AXI4-Lite registers
`timescale 1ns/10ps
// Function
// - Decode four-level clock/format strap into clock mode and output number format.
// - Decode three-level power strap: power-down, sleep or normal conversion.
// - Take each new sample on the falling edge of the selected clock input.
// - Present an 11-bit result word, bit 0 least significant.
// - Over-range flag high when input lies outside codes 0 to 2047.
// - Strobe toggles at sample rate, one result word per strobe period.
module aom_ctrl #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins from outside
    input wire logic sample_clk_p,
    input wire logic sample_clk_n,
    input wire logic [1:0] clock_format_strap,
    input wire logic [1:0] power_state_strap,
    input wire logic signed [aom_pkg::LVL_W-1:0] analog_level,
    // Result outputs and interrupt
    output logic [aom_pkg::RES_W-1:0] result_word,
    output logic over_range_flag,
    output logic output_strobe,
    output logic irq
);
    // Synchronisers
    logic p1, p2, n1, n2, clk_prev;
    logic [1:0] cf1, cf2, ps1, ps2;
    logic signed [aom_pkg::LVL_W-1:0] lv1, lv2;
    logic [1:0] next_cf1, next_ps1;
    // Core state
    aom_pkg::aom_result_t res, next_res;
    aom_pkg::aom_power_t pw_prev, next_pw_prev;
    logic strobe, next_strobe, next_clk_prev;
    logic [31:0] sample_count, next_sample_count;
    logic [aom_pkg::IRQ_W-1:0] irq_st, next_irq_st, irq_en, next_irq_en, irq_clr;
    logic standby, next_standby, next_irq;
    // Bus state
    logic aw_hold, next_aw_hold, w_hold, next_w_hold;
    logic [ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data, next_rdata;
    logic [3:0] w_strb, next_w_strb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic do_write;
    // Decoded view
    aom_pkg::aom_cfg_t cfg;
    aom_pkg::aom_power_t pw;
    aom_pkg::aom_result_t conv;
    logic clk_eff, fall, rise, active;
    logic [aom_pkg::IRQ_W-1:0] ev;

    always_comb begin
        cfg = aom_pkg::decode_cfg(cf2);
        pw = aom_pkg::decode_power(ps2);
        clk_eff = cfg.diff_clk ? (p2 & ~n2) : p2;
        fall = clk_prev & ~clk_eff;
        rise = ~clk_prev & clk_eff;
        active = (pw == aom_pkg::AOM_NORMAL) && !standby;
        conv = aom_pkg::convert(lv2, cfg.twos);
        next_cf1 = clock_format_strap;
        next_ps1 = power_state_strap;
        next_clk_prev = clk_eff;
        next_pw_prev = pw;
        next_res = res;
        next_strobe = strobe;
        next_sample_count = sample_count;
        ev = '0;
        if (!active) begin
            next_strobe = 1'b0;
        end else if (fall) begin
            next_res = conv;
            next_strobe = 1'b0;
            next_sample_count = sample_count + 32'h0000_0001;
            ev[aom_pkg::IRQ_SAMPLE] = 1'b1;
            ev[aom_pkg::IRQ_OVER] = conv.over;
        end else if (rise) begin
            next_strobe = 1'b1;
        end
        ev[aom_pkg::IRQ_POWER] = (pw != pw_prev);
        irq_clr = '0;
        next_irq_en = irq_en;
        next_standby = standby;
        if (do_write && aw_addr == aom_pkg::OFS_IRQ_CLEAR && w_strb[0]) begin
            irq_clr = w_data[aom_pkg::IRQ_W-1:0];
        end
        if (do_write && aw_addr == aom_pkg::OFS_IRQ_ENABLE && w_strb[0]) begin
            next_irq_en = w_data[aom_pkg::IRQ_W-1:0];
        end
        if (do_write && aw_addr == aom_pkg::OFS_CTRL && w_strb[0]) begin
            next_standby = w_data[0];
        end
        next_irq_st = (irq_st & ~irq_clr) | ev;
        next_irq = |(next_irq_st & next_irq_en);
    end

    always_ff @(posedge aclk) begin
        p1 <= sample_clk_p;
        p2 <= p1;
        n1 <= sample_clk_n;
        n2 <= n1;
        cf1 <= next_cf1;
        cf2 <= cf1;
        ps1 <= next_ps1;
        ps2 <= ps1;
        lv1 <= analog_level;
        lv2 <= lv1;
        // Edge history follows the pin through reset, so no false edge after release
        clk_prev <= next_clk_prev;
        if (!aresetn) begin
            pw_prev <= aom_pkg::AOM_NORMAL;
            res <= '0;
            strobe <= 1'b0;
            sample_count <= aom_pkg::RST_WORD;
            irq_st <= aom_pkg::RST_IRQ;
            irq_en <= aom_pkg::RST_IRQ;
            standby <= 1'b0;
            irq <= 1'b0;
        end else begin
            pw_prev <= next_pw_prev;
            res <= next_res;
            strobe <= next_strobe;
            sample_count <= next_sample_count;
            irq_st <= next_irq_st;
            irq_en <= next_irq_en;
            standby <= next_standby;
            irq <= next_irq;
        end
    end

    assign result_word = res.word;
    assign over_range_flag = res.over;
    assign output_strobe = strobe;

    // AXI4-Lite slave
    always_comb begin
        next_aw_hold = aw_hold;
        next_aw_addr = aw_addr;
        next_w_hold = w_hold;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_hold = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_hold = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        do_write = aw_hold && w_hold && !s_axi_bvalid;
        if (do_write) begin
            next_aw_hold = 1'b0;
            next_w_hold = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (aw_addr == aom_pkg::OFS_IRQ_CLEAR || aw_addr == aom_pkg::OFS_IRQ_ENABLE ||
                          aw_addr == aom_pkg::OFS_CTRL) ? aom_pkg::RESP_OKAY : aom_pkg::RESP_SLVERR;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = aom_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                aom_pkg::OFS_STATUS: next_rdata = {26'h0, strobe, active, pw, cfg.twos, cfg.diff_clk};
                aom_pkg::OFS_IRQ_STATUS: next_rdata = {29'h0, irq_st};
                aom_pkg::OFS_IRQ_CLEAR: next_rdata = aom_pkg::RST_WORD;
                aom_pkg::OFS_IRQ_ENABLE: next_rdata = {29'h0, irq_en};
                aom_pkg::OFS_CTRL: next_rdata = {31'h0, standby};
                aom_pkg::OFS_LAST_RESULT: next_rdata = {20'h0, res};
                aom_pkg::OFS_SAMPLE_COUNT: next_rdata = sample_count;
                default: begin
                    next_rdata = aom_pkg::RST_WORD;
                    next_rresp = aom_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_awready = !next_aw_hold && !next_bvalid;
        next_wready = !next_w_hold && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            aw_addr <= '0;
            w_hold <= 1'b0;
            w_data <= aom_pkg::RST_WORD;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= aom_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= aom_pkg::RST_WORD;
            s_axi_rresp <= aom_pkg::RESP_OKAY;
        end else begin
            aw_hold <= next_aw_hold;
            aw_addr <= next_aw_addr;
            w_hold <= next_w_hold;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // Assertions
    logic in_range;
    assign in_range = (lv2 >= aom_pkg::CODE_MIN) && (lv2 <= aom_pkg::CODE_MAX);

    twos_format_a: assert property (@(posedge aclk) disable iff (!aresetn)
        active && fall && in_range && (cf2 == aom_pkg::CF_DIFF_TWOS || cf2 == aom_pkg::CF_SE_TWOS)
        |=> result_word == {~$past(lv2[10]), $past(lv2[9:0])})
        else $error("two's complement word wrong");
    gnd_offset_a: assert property (@(posedge aclk) disable iff (!aresetn)
        active && fall && in_range && cf2 == aom_pkg::CF_SE_OFFS |=> result_word == $past(lv2[10:0]))
        else $error("offset binary word wrong for ground strap");
    power_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pw != aom_pkg::AOM_NORMAL |=> !output_strobe && $stable(result_word))
        else $error("outputs moved while powered down or asleep");
    sample_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(sample_count) |-> $past(fall) && $past(active))
        else $error("sample taken without falling clock edge");
    word_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
        active && fall && lv2 == 13'sh0001 && !cfg.twos |=> result_word == 11'h001)
        else $error("result bit order wrong");
    over_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        active && fall |=> over_range_flag == !$past(in_range))
        else $error("over-range flag wrong");
    strobe_rise_a: assert property (@(posedge aclk) disable iff (!aresetn)
        active && rise && !fall |=> output_strobe ##1 output_strobe [*1])
        else $error("strobe did not rise with sample clock");
    strobe_fall_a: assert property (@(posedge aclk) disable iff (!aresetn)
        active && fall |=> !output_strobe && sample_count == $past(sample_count) + 32'h0000_0001)
        else $error("strobe or word count wrong at sample");
endmodule // aom_ctrl

// File: dv/aom_capture.sv
// Capture logic model: latches the result word and flag on each strobe rising edge
`timescale 1ns/10ps
module aom_capture (
    // Result lines from the converter
    input wire logic output_strobe,
    input wire logic [aom_pkg::RES_W-1:0] result_word,
    input wire logic over_range_flag,
    // Captured result and capture count
    output logic [aom_pkg::RES_W:0] captured,
    output int unsigned cap_count
);
    initial begin
        captured = '0;
        cap_count = 0;
    end
    // Word and flag are taken together at the strobe rising edge
    always @(posedge output_strobe) begin
        captured <= {over_range_flag, result_word};
        cap_count <= cap_count + 1;
    end
endmodule // aom_capture

// File: dv/aom_ctrl_tb.sv
// Testbench for the converter output control block
`timescale 1ns/10ps
module aom_ctrl_tb;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic clk_p = 1, clk_n = 0, awready, wready, bvalid, arready, rvalid, over_range_flag, output_strobe, irq;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] cfs = 2'h0, pss = 2'h0, bresp, rresp, rs;
    logic signed [12:0] lvl = 13'sh0;
    logic [10:0] result_word;
    logic [11:0] captured;
    int unsigned cap_count;
    int num_errors = 0, cmp_count = 0;
    int lv[6] = '{100, -5, 3000, 2047, 0, 1};

    always #12.5 aclk = ~aclk;

    aom_ctrl u_aom_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sample_clk_p(clk_p),
        .sample_clk_n(clk_n), .clock_format_strap(cfs), .power_state_strap(pss), .analog_level(lvl),
        .result_word(result_word), .over_range_flag(over_range_flag), .output_strobe(output_strobe), .irq(irq));
    aom_capture u_aom_capture (.output_strobe(output_strobe), .result_word(result_word),
        .over_range_flag(over_range_flag), .captured(captured), .cap_count(cap_count));

    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 50) begin
            num_errors++;
            conclude();
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) awvalid <= 0;
            if (wready === 1'b1) wvalid <= 0;
        end while (bvalid !== 1'b1 && n < 50);
        r = bresp;
        bready <= 0;
        tmo(n);
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1) arvalid <= 0;
        end while (rvalid !== 1'b1 && n < 50);
        d = rdata;
        r = rresp;
        rready <= 0;
        tmo(n);
    endtask
    function automatic logic [11:0] expw(input int v, input logic twos);
        logic [10:0] ob;
        ob = (v < 0) ? 11'h000 : (v > 2047) ? 11'h7FF : v[10:0];
        return {(v < 0 || v > 2047), twos ? {~ob[10], ob[9:0]} : ob};
    endfunction
    // One 300 ns sample clock period: level settles while high, pin falls, then rises
    task automatic sample(input int v, input bit live);
        int unsigned c0;
        logic [11:0] e;
        logic [11:0] held;
        c0 = cap_count;
        e = expw(v, cfs[0]);
        held = {over_range_flag, result_word};
        lvl <= v[12:0];
        cyc(4);
        clk_p <= 0;
        clk_n <= cfs[1];
        cyc(4);
        if (live) chk({over_range_flag, result_word}, e);
        else chk({over_range_flag, result_word}, held);
        chk(output_strobe, 0);
        clk_p <= 1;
        clk_n <= 0;
        cyc(4);
        chk(cap_count, c0 + live);
        if (live) chk(captured, e);
    endtask
    task automatic t_bus();
        axw(aom_pkg::OFS_IRQ_CLEAR, 32'h7, rs);
        axr(8'h40, rd, rs);
        chk(rs, aom_pkg::RESP_SLVERR);
        chk(rd, 32'h0000_0000);
        axw(aom_pkg::OFS_STATUS, 32'h1, rs);
        chk(rs, aom_pkg::RESP_SLVERR);
    endtask
    task automatic t_format();
        for (int c = 3; c >= 0; c--) begin
            cfs <= c[1:0];
            cyc(6);
            axr(aom_pkg::OFS_STATUS, rd, rs);
            chk(rd[1:0], {c[0], c[1]});
            foreach (lv[i]) sample(lv[i], 1);
        end
    endtask
    task automatic t_power();
        for (int p = 1; p < 3; p++) begin
            pss <= p[1:0];
            cyc(6);
            axr(aom_pkg::OFS_STATUS, rd, rs);
            chk(rd[3:2], p);
            sample(300, 0);
        end
        pss <= 2'h0;
        cyc(6);
        axr(aom_pkg::OFS_STATUS, rd, rs);
        chk(rd[3:2], 0);
    endtask
    task automatic t_standby();
        axw(aom_pkg::OFS_CTRL, 32'h1, rs);
        chk(rs, aom_pkg::RESP_OKAY);
        axr(aom_pkg::OFS_STATUS, rd, rs);
        chk(rd[4], 0);
        sample(300, 0);
        axw(aom_pkg::OFS_CTRL, 32'h0, rs);
        sample(300, 1);
    endtask
    task automatic t_irq();
        logic [31:0] n0;
        axw(aom_pkg::OFS_IRQ_CLEAR, 32'h7, rs);
        axw(aom_pkg::OFS_IRQ_ENABLE, 32'h1, rs);
        axr(aom_pkg::OFS_SAMPLE_COUNT, n0, rs);
        sample(50, 1);
        chk(irq, 1);
        axr(aom_pkg::OFS_IRQ_STATUS, rd, rs);
        chk(rd[2:0], 3'h1);
        axr(aom_pkg::OFS_SAMPLE_COUNT, rd, rs);
        chk(rd, n0 + 32'h0000_0001);
        axr(aom_pkg::OFS_LAST_RESULT, rd, rs);
        chk(rd[11:0], expw(50, cfs[0]));
        axw(aom_pkg::OFS_IRQ_CLEAR, 32'h1, rs);
        cyc(2);
        chk(irq, 0);
    endtask

    initial begin
        cyc(3);
        aresetn <= 1;
        cyc(3);
        t_bus();
        t_format();
        t_power();
        t_standby();
        t_irq();
        conclude();
    end
endmodule // aom_ctrl_tb
